// File: src/sqg_pkg.sv
package sqg_pkg;
  // command word layout
  localparam int CMD_W = 16;
  localparam int GRP_HI = 15;
  localparam int GRP_LO = 12;
  localparam int SEL_HI = 1;
  localparam int SEL_LO = 0;
  localparam int HS_HI = 3;
  localparam int HS_LO = 0;
  localparam int LS_HI = 7;
  localparam int LS_LO = 4;
  localparam int MODE_HI = 15;
  localparam int MODE_LO = 8;
  localparam int N_SQ = 4;
  localparam int N_TR = 8;
  localparam int N_AN = 8;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] FRAME_SAT = 5'h11;

  // command groups (top nibble)
  localparam logic [3:0] GRP_ZERO = 4'h0;
  localparam logic [3:0] GRP_SUPPLY = 4'h1;
  localparam logic [3:0] GRP_SRC = 4'h2;
  localparam logic [3:0] GRP_AUX = 4'h3;
  localparam logic [3:0] GRP_REF = 4'h4;
  localparam logic [3:0] GRP_MAIN = 4'h6;
  localparam logic [3:0] GRP_REFMAIN = 4'h7;
  localparam logic [3:0] GRP_FIRE = 4'h8;
  localparam logic [3:0] GRP_SQOFF = 4'h9;
  localparam logic [3:0] GRP_SRC_HI = 4'hb;
  localparam logic [3:0] GRP_SWMEAS = 4'hc;
  localparam logic [7:0] MODE_CODE = 8'hfe;

  // full-word commands
  localparam logic [15:0] CMD_ZERO = 16'h0000;
  localparam logic [15:0] CMD_NOP = 16'h0001;
  localparam logic [15:0] CMD_SOFT_RST = 16'hffff;
  localparam logic [15:0] CMD_AUX_OFF = 16'h3000;
  localparam logic [15:0] CMD_AUX_ON = 16'h3001;
  localparam logic [15:0] CMD_AUX_DRAIN = 16'h1100;
  localparam logic [15:0] CMD_AUX_SOURCE = 16'h1101;
  localparam logic [15:0] CMD_LAMP_CUR = 16'h1102;
  localparam logic [15:0] CMD_CHIP_TEMP = 16'h1103;

  // analogue input bit positions
  localparam int AN_BOOST = 0;
  localparam int AN_LOGIC = 1;
  localparam int AN_AUX_OT = 2;
  localparam int AN_AVG_T = 3;
  localparam int AN_FC1 = 4;
  localparam int AN_FC2 = 5;
  localparam int AN_LAMP = 6;
  localparam int AN_SPARE = 7;

  typedef enum logic [1:0] {
    SQG_IDLE = 2'b00,
    SQG_FIRE = 2'b01,
    SQG_REFMAIN = 2'b11,
    SQG_SWMEAS = 2'b10
  } sqg_kind_t;

  typedef enum logic [2:0] {
    SQG_MS_NONE = 3'h0,
    SQG_MS_AUX_DRAIN = 3'h1,
    SQG_MS_AUX_SOURCE = 3'h2,
    SQG_MS_LAMP_CUR = 3'h3,
    SQG_MS_CHIP_TEMP = 3'h4,
    SQG_MS_VI_SENSE = 3'h5,
    SQG_MS_SQUIB = 3'h6,
    SQG_MS_SUPPLY = 3'h7
  } sqg_meas_t;
endpackage

// File: src/sqg_cmd_if.sv
`timescale 1ns/1ps
interface sqg_cmd_if;
  import sqg_pkg::*;
  logic [CMD_W-1:0] word;
  logic valid;
  modport src (output word, output valid);
  modport dst (input word, input valid);
endinterface

// File: src/sqg_sync.sv
`timescale 1ns/1ps
module sqg_sync import sqg_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [N_AN-1:0] async_in,
  output logic [N_AN-1:0] sync_out
);
  logic [N_AN-1:0] stage_reg;

  // two-flop synchroniser, first stage feeds only the second
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule

// File: src/sqg_cmd_latch.sv
`timescale 1ns/1ps
module sqg_cmd_latch import sqg_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [CMD_W-1:0] shift_word_in,
  input wire logic serial_clk_rise_in,
  input wire logic chip_select_n_in,
  sqg_cmd_if.src cmd
);
  logic [4:0] count_reg;
  logic cs_n_q_reg;
  logic cs_rise;

  assign cs_rise = chip_select_n_in & ~cs_n_q_reg;

  // count serial clock edges inside a frame, saturating past 16
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
      cs_n_q_reg <= 1'b1;
    end else begin
      cs_n_q_reg <= chip_select_n_in;
      if (chip_select_n_in) begin
        count_reg <= '0;
      end else if (serial_clk_rise_in && count_reg != FRAME_SAT) begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end

  // latch only frames with exactly sixteen clocks
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd.word <= '0;
      cmd.valid <= 1'b0;
    end else begin
      cmd.valid <= cs_rise && count_reg == FRAME_BITS;
      if (cs_rise && count_reg == FRAME_BITS) begin
        cmd.word <= shift_word_in;
      end
    end
  end
endmodule

// File: src/sqg_gate.sv
`timescale 1ns/1ps
// Behaviour
// - aux driver starts off, on by command
// - aux driver off on supply loss, reset
// - lamp polarity pin ignored for aux driver
// - aux overtemperature latches off the driver
// - aux overtemperature flag cleared by off command
// - aux drain/source voltages routed to output
// - lamp current shown as two-level output
// - 2xxx enables one source at low level
// - bxxx drives addressed source at high level
// - squib fires only with both switches closed
// - firing needs reset high, both fire enables
// - default config: 8xxx closes selected switches if group12 pin high, group34 pin low
// - alternate config: 8xxx fires by group pins
// - default config measurement commands pin-gated
// - alternate measurement needs both pins low
// - processor reset aborts, returns to default
// - soft reset keeps selected configuration
// - firing current drives leak flags low
// - hot toggling transistor latched off
// - listed commands clear thermal off-latch
// - alternate config needs pin and command
// - internal fire enable gates firing
// - command latched only after sixteen clocks
module sqg_gate import sqg_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [CMD_W-1:0] shift_word_in,
  input wire logic serial_clk_rise_in,
  input wire logic chip_select_n_in,
  input wire logic processor_reset_n_in,
  input wire logic fire_enable_internal_in,
  input wire logic fire_enable_pin_in,
  input wire logic group12_enable_pin_in,
  input wire logic group34_enable_pin_in,
  input wire logic config_pin_in,
  input wire logic lamp_polarity_pin_in,
  input wire logic boost_supply_ok_in,
  input wire logic logic_supply_five_ok_in,
  input wire logic aux_overtemp_in,
  input wire logic avg_temp_high_in,
  input wire logic [N_TR-1:0] thermal_toggle_in,
  input wire logic [1:0] fire_current_high_in,
  input wire logic lamp_current_high_in,
  output logic fire_enable_pin_out,
  output logic fire_enable_pin_oe_out,
  output logic aux_load_driver_on_out,
  output logic aux_overtemp_flag_out,
  output logic [N_SQ-1:0] highside_switch_out,
  output logic [N_SQ-1:0] lowside_switch_out,
  output logic [N_SQ-1:0] vi_source_pin_en_out,
  output logic vi_source_high_out,
  output logic [2:0] analog_measure_sel_out,
  output logic lamp_open_load_level_out,
  output logic low_leak_flag_out,
  output logic high_leak_flag_out,
  output logic alternate_config_out
);
  sqg_cmd_if cmd_bus ();
  logic [N_AN-1:0] an_raw, an_sync;
  logic [N_TR-1:0] tog_sync, therm_off_reg, sw_on;
  sqg_kind_t kind_reg;
  sqg_meas_t meas_reg;
  logic [N_SQ-1:0] hs_mask_reg, ls_mask_reg, src_en_reg, hs_next, ls_next;
  logic src_high_reg, mode_cmd_reg, aux_on_reg, aux_ot_reg;
  logic alt_cfg, decode_ok, cmd_go, fire_ok, supply_ok, therm_clear;
  logic [3:0] grp;

  // clearing commands for the thermal off-latch
  function automatic logic is_clear_cmd(input logic [CMD_W-1:0] w);
    logic [3:0] g;
    g = w[GRP_HI:GRP_LO];
    is_clear_cmd = w == CMD_ZERO || w == CMD_NOP || g == GRP_SQOFF
      || g == GRP_SUPPLY || g == GRP_SRC || g == GRP_SRC_HI
      || g == GRP_REF || g == GRP_MAIN || g == GRP_REFMAIN
      || g == GRP_SWMEAS;
  endfunction

  // one-hot squib select from the two select bits
  function automatic logic [N_SQ-1:0] sel_onehot(input logic [1:0] s);
    sel_onehot = '0;
    sel_onehot[s] = 1'b1;
  endfunction

  sqg_cmd_latch u_latch (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .shift_word_in(shift_word_in),
    .serial_clk_rise_in(serial_clk_rise_in),
    .chip_select_n_in(chip_select_n_in),
    .cmd(cmd_bus.src)
  );

  // analogue conditions enter through the synchroniser
  assign an_raw = {1'b0, lamp_current_high_in, fire_current_high_in,
    avg_temp_high_in, aux_overtemp_in, logic_supply_five_ok_in,
    boost_supply_ok_in};

  sqg_sync u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(an_raw),
    .sync_out(an_sync)
  );

  // per-transistor toggle flags, two flops as well
  sqg_sync u_tog_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(thermal_toggle_in),
    .sync_out(tog_sync)
  );

  // decode qualifiers
  assign grp = cmd_bus.word[GRP_HI:GRP_LO];
  assign alt_cfg = config_pin_in & mode_cmd_reg;
  assign decode_ok = ~config_pin_in | mode_cmd_reg;
  assign cmd_go = cmd_bus.valid & processor_reset_n_in;
  assign supply_ok = an_sync[AN_BOOST] & an_sync[AN_LOGIC];
  assign fire_ok = processor_reset_n_in & fire_enable_pin_in
    & fire_enable_internal_in;
  assign therm_clear = cmd_go & is_clear_cmd(cmd_bus.word);

  // configuration: set by mode command, dropped by processor reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_cmd_reg <= 1'b0;
    end else if (!processor_reset_n_in) begin
      mode_cmd_reg <= 1'b0;
    end else if (cmd_go && cmd_bus.word[MODE_HI:MODE_LO] == MODE_CODE) begin
      mode_cmd_reg <= 1'b1;
    end
  end

  // squib command kind and switch masks
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kind_reg <= SQG_IDLE;
      hs_mask_reg <= '0;
      ls_mask_reg <= '0;
    end else if (!processor_reset_n_in
                 || (cmd_go && cmd_bus.word == CMD_SOFT_RST)) begin
      kind_reg <= SQG_IDLE;
      hs_mask_reg <= '0;
      ls_mask_reg <= '0;
    end else if (cmd_go && decode_ok) begin
      case (grp)
        GRP_FIRE: begin
          kind_reg <= SQG_FIRE;
          hs_mask_reg <= cmd_bus.word[HS_HI:HS_LO];
          ls_mask_reg <= cmd_bus.word[LS_HI:LS_LO];
        end
        GRP_REFMAIN: begin
          kind_reg <= SQG_REFMAIN;
          hs_mask_reg <= sel_onehot(cmd_bus.word[SEL_HI:SEL_LO]);
          ls_mask_reg <= '0;
        end
        GRP_SWMEAS: begin
          kind_reg <= SQG_SWMEAS;
          hs_mask_reg <= cmd_bus.word[HS_HI:HS_LO];
          ls_mask_reg <= cmd_bus.word[LS_HI:LS_LO];
        end
        GRP_ZERO, GRP_SQOFF, GRP_SUPPLY, GRP_REF, GRP_MAIN, GRP_SRC,
        GRP_SRC_HI: begin
          kind_reg <= SQG_IDLE;
          hs_mask_reg <= '0;
          ls_mask_reg <= '0;
        end
        default: kind_reg <= kind_reg;
      endcase
    end
  end

  // switch permission from live pins and stored command
  always_comb begin
    hs_next = '0;
    ls_next = '0;
    case (kind_reg)
      SQG_FIRE: begin
        if (!alt_cfg && fire_ok && group12_enable_pin_in
            && !group34_enable_pin_in) begin
          hs_next = hs_mask_reg;
          ls_next = ls_mask_reg;
        end else if (alt_cfg && fire_ok) begin
          hs_next = {group34_enable_pin_in, group34_enable_pin_in,
            group12_enable_pin_in, group12_enable_pin_in};
          ls_next = hs_next;
        end
      end
      SQG_REFMAIN: begin
        if (!alt_cfg && fire_enable_internal_in && group12_enable_pin_in
            && group34_enable_pin_in) begin
          hs_next = hs_mask_reg;
        end else if (alt_cfg && fire_enable_internal_in
                     && !group12_enable_pin_in
                     && !group34_enable_pin_in) begin
          hs_next = hs_mask_reg;
        end
      end
      SQG_SWMEAS: begin
        if (!alt_cfg) begin
          if (fire_enable_internal_in && group12_enable_pin_in) begin
            hs_next = hs_mask_reg;
          end
          if (fire_enable_internal_in && !group34_enable_pin_in) begin
            ls_next = ls_mask_reg;
          end
        end else if (fire_enable_internal_in && !group12_enable_pin_in
                     && !group34_enable_pin_in) begin
          hs_next = hs_mask_reg;
          ls_next = ls_mask_reg;
        end
      end
      default: hs_next = '0;
    endcase
    if (!processor_reset_n_in) begin
      hs_next = '0;
      ls_next = '0;
    end
    hs_next = hs_next & ~therm_off_reg[N_SQ-1:0];
    ls_next = ls_next & ~therm_off_reg[N_TR-1:N_SQ];
  end

  // thermal off-latch per transistor, set beats clear
  assign sw_on = {lowside_switch_out, highside_switch_out};
  genvar t;
  generate
    for (t = 0; t < N_TR; t++) begin : g_therm
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          therm_off_reg[t] <= 1'b0;
        end else if (sw_on[t] && tog_sync[t] && an_sync[AN_AVG_T]) begin
          therm_off_reg[t] <= 1'b1;
        end else if (therm_clear) begin
          therm_off_reg[t] <= 1'b0;
        end
      end
    end
  endgenerate

  // squib switch outputs
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      highside_switch_out <= '0;
      lowside_switch_out <= '0;
    end else begin
      highside_switch_out <= hs_next;
      lowside_switch_out <= ls_next;
    end
  end

  // firing current reported on leak flags, active low
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_leak_flag_out <= 1'b1;
      high_leak_flag_out <= 1'b1;
    end else begin
      low_leak_flag_out <= ~(lowside_switch_out[0] & an_sync[AN_FC1]);
      high_leak_flag_out <= ~(lowside_switch_out[1] & an_sync[AN_FC2]);
    end
  end

  // aux driver on-latch and overtemperature latch
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_on_reg <= 1'b0;
      aux_ot_reg <= 1'b0;
    end else begin
      if (aux_on_reg && an_sync[AN_AUX_OT]) begin
        aux_ot_reg <= 1'b1;
      end else if (cmd_go && decode_ok && cmd_bus.word == CMD_AUX_OFF) begin
        aux_ot_reg <= 1'b0;
      end
      if (!processor_reset_n_in) begin
        aux_on_reg <= 1'b0;
      end else if (aux_on_reg && an_sync[AN_AUX_OT]) begin
        aux_on_reg <= 1'b0;
      end else if (cmd_go && decode_ok) begin
        if (cmd_bus.word == CMD_AUX_ON) begin
          aux_on_reg <= 1'b1;
        end else if (cmd_bus.word == CMD_AUX_OFF
                     || cmd_bus.word == CMD_SOFT_RST) begin
          aux_on_reg <= 1'b0;
        end
      end
    end
  end

  // aux outputs; the lamp polarity pin never enters this path
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_load_driver_on_out <= 1'b0;
      aux_overtemp_flag_out <= 1'b0;
    end else begin
      aux_load_driver_on_out <= aux_on_reg & supply_ok
        & processor_reset_n_in;
      aux_overtemp_flag_out <= aux_ot_reg;
    end
  end

  // measurement source selection and voltage/current sources
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meas_reg <= SQG_MS_NONE;
      src_en_reg <= '0;
      src_high_reg <= 1'b0;
    end else if (!processor_reset_n_in
                 || (cmd_go && cmd_bus.word == CMD_SOFT_RST)) begin
      meas_reg <= SQG_MS_NONE;
      src_en_reg <= '0;
      src_high_reg <= 1'b0;
    end else if (cmd_go && decode_ok) begin
      src_en_reg <= '0;
      src_high_reg <= 1'b0;
      if (cmd_bus.word == CMD_AUX_DRAIN) begin
        meas_reg <= SQG_MS_AUX_DRAIN;
      end else if (cmd_bus.word == CMD_AUX_SOURCE) begin
        meas_reg <= SQG_MS_AUX_SOURCE;
      end else if (cmd_bus.word == CMD_LAMP_CUR) begin
        meas_reg <= SQG_MS_LAMP_CUR;
      end else if (cmd_bus.word == CMD_CHIP_TEMP) begin
        meas_reg <= SQG_MS_CHIP_TEMP;
      end else if (grp == GRP_SRC) begin
        meas_reg <= SQG_MS_VI_SENSE;
        src_en_reg <= sel_onehot(cmd_bus.word[SEL_HI:SEL_LO]);
      end else if (grp == GRP_SRC_HI) begin
        meas_reg <= SQG_MS_VI_SENSE;
        src_en_reg <= sel_onehot(cmd_bus.word[SEL_HI:SEL_LO]);
        src_high_reg <= 1'b1;
      end else if (grp == GRP_REF || grp == GRP_MAIN
                   || grp == GRP_REFMAIN || grp == GRP_SWMEAS) begin
        meas_reg <= SQG_MS_SQUIB;
      end else if (grp == GRP_SUPPLY) begin
        meas_reg <= SQG_MS_SUPPLY;
      end else begin
        src_en_reg <= src_en_reg;
        src_high_reg <= src_high_reg;
      end
    end
  end

  // measurement outputs and configuration status
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      analog_measure_sel_out <= SQG_MS_NONE;
      vi_source_pin_en_out <= '0;
      vi_source_high_out <= 1'b0;
      lamp_open_load_level_out <= 1'b0;
      alternate_config_out <= 1'b0;
    end else begin
      analog_measure_sel_out <= meas_reg;
      vi_source_pin_en_out <= src_en_reg;
      vi_source_high_out <= src_high_reg;
      lamp_open_load_level_out <= (meas_reg == SQG_MS_LAMP_CUR)
        & an_sync[AN_LAMP];
      alternate_config_out <= alt_cfg;
    end
  end

  // open-drain fire-enable pin pulled low while internal enable is low
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fire_enable_pin_out <= 1'b0;
      fire_enable_pin_oe_out <= 1'b1;
    end else begin
      fire_enable_pin_out <= 1'b0;
      fire_enable_pin_oe_out <= ~fire_enable_internal_in;
    end
  end
endmodule

// File: bench/sqg_gate_checker.sv
`timescale 1ns/1ps
// watches gating outputs against supply, reset and enable inputs
module sqg_gate_checker import sqg_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic processor_reset_n_in,
  input wire logic fire_enable_internal_in,
  input wire logic boost_supply_ok_in,
  input wire logic logic_supply_five_ok_in,
  input wire logic aux_load_driver_on_out,
  input wire logic aux_overtemp_flag_out,
  input wire logic [N_SQ-1:0] highside_switch_out,
  input wire logic [N_SQ-1:0] lowside_switch_out,
  input wire logic [N_SQ-1:0] vi_source_pin_en_out,
  input wire logic vi_source_high_out,
  input wire logic [2:0] analog_measure_sel_out,
  input wire logic lamp_open_load_level_out,
  input wire logic low_leak_flag_out,
  input wire logic high_leak_flag_out,
  input wire logic alternate_config_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  // a supply missing long enough to pass the synchronisers
  sequence supply_lost_s;
    (!(boost_supply_ok_in && logic_supply_five_ok_in)) [*4];
  endsequence
  // processor reset held low past the output registers
  sequence proc_reset_s;
    (!processor_reset_n_in) [*3];
  endsequence
  aux_supply_off_a: assert property (supply_lost_s |->
    !aux_load_driver_on_out) else $error("aux on without supply");
  proc_reset_clr_a: assert property (proc_reset_s |->
    !alternate_config_out && !aux_load_driver_on_out &&
    highside_switch_out == 4'h0) else $error("reset left outputs on");
  fire_permit_a: assert property (
    |(highside_switch_out & lowside_switch_out) |->
    $past(processor_reset_n_in) && $past(fire_enable_internal_in))
    else $error("squib closed without permission");
  aux_ot_off_a: assert property ($rose(aux_overtemp_flag_out) |->
    !aux_load_driver_on_out) else $error("aux on at overtemp");
  low_leak_a: assert property (!low_leak_flag_out |->
    $past(lowside_switch_out[0])) else $error("low flag without switch");
  high_leak_a: assert property (!high_leak_flag_out |->
    $past(lowside_switch_out[1])) else $error("high flag without switch");
  lamp_level_a: assert property (lamp_open_load_level_out |->
    analog_measure_sel_out == SQG_MS_LAMP_CUR ||
    $past(analog_measure_sel_out) == SQG_MS_LAMP_CUR)
    else $error("lamp level without lamp select");
  src_onehot_a: assert property ($onehot0(vi_source_pin_en_out))
    else $error("more than one source enabled");
  src_high_a: assert property (vi_source_high_out |->
    vi_source_pin_en_out != 4'h0) else $error("high level, no source");
endmodule

bind sqg_gate sqg_gate_checker sqg_gate_checker_i (
  .clock_in, .rst_n_in, .processor_reset_n_in, .fire_enable_internal_in,
  .boost_supply_ok_in, .logic_supply_five_ok_in, .aux_load_driver_on_out,
  .aux_overtemp_flag_out, .highside_switch_out, .lowside_switch_out,
  .vi_source_pin_en_out, .vi_source_high_out, .analog_measure_sel_out,
  .lamp_open_load_level_out, .low_leak_flag_out, .high_leak_flag_out,
  .alternate_config_out
);

// File: bench/sqg_mcu_model.sv
`timescale 1ns/1ps
// controller side: shifts a command in msb first, then closes the frame
module sqg_mcu_model (
  input wire logic clock_in,
  output logic [15:0] shift_word_out,
  output logic serial_clk_rise_out,
  output logic chip_select_n_out
);
  // idle: select released, no serial clock
  initial begin
    shift_word_out = 16'h0000;
    serial_clk_rise_out = 1'b0;
    chip_select_n_out = 1'b1;
  end
  // n other than 16 makes a faulty frame
  task automatic send_frame(input logic [15:0] w, input int n);
    @(posedge clock_in);
    chip_select_n_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in);
      shift_word_out <= {shift_word_out[14:0], w[15 - (i % 16)]};
      serial_clk_rise_out <= 1'b1;
      @(posedge clock_in);
      serial_clk_rise_out <= 1'b0;
    end
    @(posedge clock_in);
    chip_select_n_out <= 1'b1;
    @(posedge clock_in);
  endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import sqg_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, prst_n = 1'b1, fe_int = 1'b1;
  logic ext_low = 1'b0, g12 = 1'b1, g34 = 1'b0, cfg = 1'b0, pol = 1'b0;
  logic boost = 1'b1, vcc = 1'b1, aux_ot = 1'b0, avg_hot = 1'b0;
  logic lamp_hi = 1'b0, sclk, cs_n, fe_o, fe_oe, aux_on, aux_fl, vi_hi;
  logic lamp_lvl, ll_n, lh_n, alt;
  logic [7:0] tgl = 8'h00;
  logic [1:0] fc = 2'h0;
  logic [15:0] sw;
  logic [3:0] hs, ls, vi_en;
  logic [2:0] sel;
  int failures = 0;
  int tests_run = 0;
  // open-drain pin: low if either side pulls it
  wire fe_pin = !fe_oe && !ext_low;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  sqg_gate sqg_gate_i (
    .clock_in(clk), .rst_n_in(rst_n), .shift_word_in(sw),
    .serial_clk_rise_in(sclk), .chip_select_n_in(cs_n),
    .processor_reset_n_in(prst_n), .fire_enable_internal_in(fe_int),
    .fire_enable_pin_in(fe_pin), .group12_enable_pin_in(g12),
    .group34_enable_pin_in(g34), .config_pin_in(cfg),
    .lamp_polarity_pin_in(pol), .boost_supply_ok_in(boost),
    .logic_supply_five_ok_in(vcc), .aux_overtemp_in(aux_ot),
    .avg_temp_high_in(avg_hot), .thermal_toggle_in(tgl),
    .fire_current_high_in(fc), .lamp_current_high_in(lamp_hi),
    .fire_enable_pin_out(fe_o), .fire_enable_pin_oe_out(fe_oe),
    .aux_load_driver_on_out(aux_on), .aux_overtemp_flag_out(aux_fl),
    .highside_switch_out(hs), .lowside_switch_out(ls),
    .vi_source_pin_en_out(vi_en), .vi_source_high_out(vi_hi),
    .analog_measure_sel_out(sel), .lamp_open_load_level_out(lamp_lvl),
    .low_leak_flag_out(ll_n), .high_leak_flag_out(lh_n),
    .alternate_config_out(alt)
  );
  sqg_mcu_model sqg_mcu_model_i (
    .clock_in(clk), .shift_word_out(sw), .serial_clk_rise_out(sclk),
    .chip_select_n_out(cs_n)
  );

  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // let synchronisers and outputs follow
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic cmd(input logic [15:0] w);
    sqg_mcu_model_i.send_frame(w, 16);
    settle();
  endtask
  task automatic finish_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // aux driver: start, command, supplies, overtemperature
  task automatic t_aux();
    check(16'(aux_on), 16'h0, "aux idle");
    cmd(CMD_AUX_ON);
    check(16'(aux_on), 16'h1, "aux on");
    pol <= 1'b1;
    settle();
    check(16'(aux_on), 16'h1, "polarity");
    boost <= 1'b0;
    settle();
    check(16'(aux_on), 16'h0, "boost lost");
    boost <= 1'b1;
    vcc <= 1'b0;
    settle();
    check(16'(aux_on), 16'h0, "vcc lost");
    vcc <= 1'b1;
    settle();
    check(16'(aux_on), 16'h1, "supply back");
    aux_ot <= 1'b1;
    settle();
    check(16'({aux_on, aux_fl}), 16'h1, "overtemp");
    aux_ot <= 1'b0;
    cmd(CMD_CHIP_TEMP);
    check(16'({aux_fl, sel}), 16'({1'b1, SQG_MS_CHIP_TEMP}), "kept");
    cmd(CMD_AUX_OFF);
    check(16'(aux_fl), 16'h0, "flag clear");
    cmd(CMD_AUX_ON);
    prst_n <= 1'b0;
    settle();
    check(16'(aux_on), 16'h0, "proc reset");
    prst_n <= 1'b1;
  endtask
  // measurement routing and lamp level
  task automatic t_meas();
    cmd(CMD_AUX_DRAIN);
    check(16'(sel), 16'(SQG_MS_AUX_DRAIN), "drain");
    cmd(CMD_AUX_SOURCE);
    check(16'(sel), 16'(SQG_MS_AUX_SOURCE), "source");
    cmd(CMD_LAMP_CUR);
    lamp_hi <= 1'b1;
    settle();
    check(16'(lamp_lvl), 16'h1, "lamp high");
    lamp_hi <= 1'b0;
    settle();
    check(16'(lamp_lvl), 16'h0, "lamp low");
  endtask
  // every source at both levels
  task automatic t_src();
    for (int k = 0; k < 4; k++) begin
      cmd(16'h2000 | 16'(k));
      check(16'({vi_hi, vi_en}), 16'h1 << k, "src low");
      cmd(16'hb000 | 16'(k));
      check(16'({vi_hi, vi_en}), 16'h10 | (16'h1 << k), "src high");
    end
  endtask
  // default configuration firing, leak flags
  task automatic t_fire();
    cmd(16'h8033);
    check({8'h0, hs, ls}, 16'h0033, "fire");
    fc <= 2'b01;
    settle();
    check(16'({ll_n, lh_n}), 16'h1, "leak 1");
    fc <= 2'b10;
    settle();
    check(16'({ll_n, lh_n}), 16'h2, "leak 2");
    fc <= 2'b00;
    ext_low <= 1'b1;
    settle();
    check(16'(hs & ls), 16'h0, "pin low");
    ext_low <= 1'b0;
    fe_int <= 1'b0;
    cmd(16'h8011);
    check(16'(hs & ls), 16'h0, "int low");
    check(16'({fe_o, fe_oe}), 16'h1, "pin pulled");
    fe_int <= 1'b1;
    g34 <= 1'b1;
    cmd(16'h7000);
    check(16'(hs), 16'h1, "ref main");
    cmd(16'hc010);
    check(16'(ls), 16'h0, "ls blocked");
    g34 <= 1'b0;
    cmd(16'hc010);
    check(16'(ls), 16'h1, "ls meas");
    cmd(16'h9000);
  endtask
  // thermal latch and the zero, no-op, squib-off and supply-group clearing commands
  task automatic t_therm();
    for (int k = 0; k < 4; k++) begin
      cmd(16'h8011);
      avg_hot <= 1'b1;
      tgl <= 8'h01;
      settle();
      check(16'(hs), 16'h0, "latched");
      tgl <= 8'h00;
      cmd(16'h8011);
      check(16'(hs), 16'h0, "still off");
      avg_hot <= 1'b0;
      cmd(k == 0 ? CMD_ZERO : k == 1 ? CMD_NOP : k == 2 ? 16'h9000 :
          CMD_CHIP_TEMP);
      cmd(16'h8011);
      check(16'(hs), 16'h1, "resumed");
    end
    cmd(16'h9000);
  endtask
  // frames with a wrong clock count are dropped
  task automatic t_frame();
    sqg_mcu_model_i.send_frame(CMD_AUX_ON, 15);
    settle();
    check(16'(aux_on), 16'h0, "15 clocks");
    sqg_mcu_model_i.send_frame(CMD_AUX_ON, 17);
    settle();
    check(16'(aux_on), 16'h0, "17 clocks");
    cmd(CMD_AUX_ON);
    check(16'(aux_on), 16'h1, "16 clocks");
    cmd(CMD_AUX_OFF);
  endtask
  // alternate configuration entry, firing, exit
  task automatic t_mode();
    logic [3:0] m;
    cfg <= 1'b1;
    cmd(CMD_AUX_ON);
    check(16'({alt, aux_on}), 16'h0, "no mode cmd");
    cmd(16'hfe00);
    cmd(CMD_SOFT_RST);
    check(16'(alt), 16'h1, "mode kept");
    for (int k = 1; k < 4; k++) begin
      m = {k[1], k[1], k[0], k[0]};
      g12 <= k[0];
      g34 <= k[1];
      cmd(16'h8000);
      check({8'h0, hs, ls}, {8'h0, m, m}, "group fire");
      cmd(16'h9000);
    end
    g12 <= 1'b0;
    g34 <= 1'b0;
    ext_low <= 1'b1;
    cmd(16'hc011);
    check(16'(hs), 16'h1, "alt meas");
    g12 <= 1'b1;
    settle();
    check(16'(hs), 16'h0, "alt blocked");
    ext_low <= 1'b0;
    prst_n <= 1'b0;
    settle();
    check(16'(alt), 16'h0, "default again");
    prst_n <= 1'b1;
    cfg <= 1'b0;
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check(16'({ll_n, lh_n}), 16'h3, "leak idle");
    t_aux();
    t_meas();
    t_src();
    t_fire();
    t_therm();
    t_frame();
    t_mode();
    finish_test();
  end
  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    finish_test();
  end
endmodule
